// file: include/tcc_pkg.sv
// tcc_pkg: constants for the 16-bit timer / capture counter block
// assumes an apb slave with 32-bit data and word-aligned registers
package tcc_pkg;

    // register byte addresses
    localparam logic [7:0] TCC_CTRL_OFS  = 8'h00;  // timer control register
    localparam logic [7:0] TCC_COUNT_OFS = 8'h04;  // count high/low bytes
    localparam logic [7:0] TCC_CAPT_OFS  = 8'h08;  // capture high/low bytes
    localparam logic [7:0] TCC_STAT_OFS  = 8'h0c;  // sticky flags, write one to clear
    localparam logic [7:0] TCC_MASK_OFS  = 8'h10;  // interrupt mask

    // control register field positions
    localparam int TCC_CT_SEL_BIT  = 0;  // counter_timer_select
    localparam int TCC_RUN_BIT     = 1;  // run_control
    localparam int TCC_CPRL_BIT    = 2;  // capture_reload_select
    localparam int TCC_EXEN_BIT    = 3;  // external_trigger_enable
    localparam int TCC_TXBAUD_BIT  = 4;  // transmit_baud_select
    localparam int TCC_RXBAUD_BIT  = 5;  // receive baud select

    // status / mask field positions
    localparam int TCC_OVF_BIT = 0;  // overflow_flag
    localparam int TCC_EXF_BIT = 1;  // external_trigger_flag

    // reset values
    localparam logic [5:0]  TCC_CTRL_RST  = 6'h00;
    localparam logic [15:0] TCC_COUNT_RST = 16'h0000;
    localparam logic [1:0]  TCC_FLAG_RST  = 2'h0;

    // machine cycle timing: 12 oscillator periods per machine cycle
    localparam int         TCC_OSC_PER_MC   = 12;
    localparam logic [3:0] TCC_MC_LAST      = 4'hb;  // phase counter wraps here
    localparam logic [3:0] TCC_SAMPLE_PHASE = 4'h9;  // sample_phase within cycle
    localparam logic [3:0] TCC_UPDATE_PHASE = 4'h4;  // update_phase within cycle

    // operating mode decode
    typedef enum logic [1:0] {
        TCC_OFF     = 2'b00,
        TCC_RELOAD  = 2'b01,
        TCC_CAPTURE = 2'b11,
        TCC_BAUD    = 2'b10
    } tcc_mode_t;

endpackage

// file: logic/tcc_timer.sv
// tcc_timer: 16-bit timer / event counter with capture and reload
// assumes pclk is the oscillator clock and pin inputs are synchronous to it
`timescale 1ns/1ns
`default_nettype none

module tcc_timer
    import tcc_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // external pins
    input  wire logic        event_count_input,
    input  wire logic        external_trigger_input,
    // interrupt and status
    output logic             irq,
    output logic             baud_tick
);

    // register state
    // everything below is clocked by pclk, which stands in for the
    // oscillator; a machine cycle is twelve pclk periods counted by phase_q,
    // and the two pin strobes plus the timer step are decoded from it.
    // the phase counter free-runs from reset, so a run bit set by software
    // starts counting at whatever phase the counter has reached: the first
    // timer step may come anywhere from one to twelve clocks later.
    logic [3:0]  phase_q, phase_d;      // oscillator period within machine cycle
    logic [5:0]  ctrl_q, ctrl_d;        // timer_control_reg
    logic [7:0]  count_high_byte_q, count_high_byte_d;
    logic [7:0]  count_low_byte_q, count_low_byte_d;
    logic [7:0]  capture_high_byte_q, capture_high_byte_d;
    logic [7:0]  capture_low_byte_q, capture_low_byte_d;
    logic [1:0]  flag_q, flag_d;        // sticky overflow / trigger flags
    logic [1:0]  mask_q, mask_d;        // interrupt enables
    logic        ev_smp_q, ev_smp_d;    // last event pin sample
    logic        tr_smp_q, tr_smp_d;    // last trigger pin sample
    logic        ev_pend_q, ev_pend_d;  // edge seen, count at next update phase
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic        irq_q, irq_d;
    logic        baud_q, baud_d;

    // decoded control
    // plain wires onto the control register bits; kept as named signals so
    // the mode decode and the increment source read like the bit names.
    // receive baud select has no pin of its own here, only its bit
    logic        counter_timer_select;
    logic        run_control;
    logic        capture_reload_select;
    logic        external_trigger_enable;
    logic        transmit_baud_select;
    logic        receive_baud_select;
    tcc_mode_t   mode;

    // combinational helpers
    logic        mc_end;         // last oscillator period of machine cycle
    logic        at_sample;      // sample_phase strobe
    logic        at_update;      // update_phase strobe
    logic        inc;            // count advances this clock
    logic [16:0] next_count;     // count plus one with carry out
    logic        overflow;       // wrap from all ones to zero
    logic        trig_fall;      // falling edge on trigger input
    logic        wr_en;          // apb write access phase
    logic        rd_en;          // apb read access phase
    logic        addr_ok;        // address decodes to a register

    assign counter_timer_select    = ctrl_q[TCC_CT_SEL_BIT];
    assign run_control             = ctrl_q[TCC_RUN_BIT];
    assign capture_reload_select   = ctrl_q[TCC_CPRL_BIT];
    assign external_trigger_enable = ctrl_q[TCC_EXEN_BIT];
    assign transmit_baud_select    = ctrl_q[TCC_TXBAUD_BIT];
    assign receive_baud_select     = ctrl_q[TCC_RXBAUD_BIT];

    // mode decode; baud selects override the capture/reload choice
    // run control is tested first so that no combination of the other
    // bits can keep the counter alive once software stops it; the enum
    // is gray coded so neighbouring modes differ in a single bit
    always_comb begin
        if (!run_control) begin
            mode = TCC_OFF;
        end else if (transmit_baud_select || receive_baud_select) begin
            mode = TCC_BAUD;
        end else if (capture_reload_select) begin
            mode = TCC_CAPTURE;
        end else begin
            mode = TCC_RELOAD;
        end
    end

    // phase strobes within a machine cycle
    // each strobe is high for exactly one pclk in twelve; the sample strobe
    // lies late in the cycle and the update strobe early, so an edge seen
    // at one sample is counted part way into the following machine cycle.
    // the timer step uses the last phase so that one step happens per
    // machine cycle whatever phase the run bit was set at
    assign mc_end    = (phase_q == TCC_MC_LAST);
    assign at_sample = (phase_q == TCC_SAMPLE_PHASE);
    assign at_update = (phase_q == TCC_UPDATE_PHASE);

    // the increment source: machine cycles or a pending pin edge;
    // the edge is only consumed at the update phase, so two machine
    // cycles separate successive counts at best
    always_comb begin
        if (mode == TCC_OFF) begin
            inc = 1'b0;
        end else if (counter_timer_select) begin
            inc = at_update && ev_pend_q;
        end else begin
            inc = mc_end;
        end
    end

    // low byte carries into high byte as one 16-bit value
    assign next_count = {1'b0, count_high_byte_q, count_low_byte_q} + 17'h00001;
    assign overflow   = inc && next_count[16];

    // trigger edge detect at sample phase, same sampling as count pin
    assign trig_fall = at_sample && tr_smp_q && !external_trigger_input;

    // apb decode
    // writes act in the access cycle, the one cycle in which pready is
    // high; reads are looked up in the setup cycle and registered so that
    // prdata comes from a flip-flop; the price is that a read shows the
    // state one clock before the access edge, never a value still changing
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign addr_ok = (paddr == TCC_CTRL_OFS) || (paddr == TCC_COUNT_OFS) ||
                     (paddr == TCC_CAPT_OFS) || (paddr == TCC_STAT_OFS) ||
                     (paddr == TCC_MASK_OFS);

    // next-state logic for the whole block
    always_comb begin
        // defaults hold state, except that the phase counter advances and baud_d clears
        phase_d             = mc_end ? 4'h0 : phase_q + 4'h1;
        ctrl_d              = ctrl_q;
        count_high_byte_d   = count_high_byte_q;
        count_low_byte_d    = count_low_byte_q;
        capture_high_byte_d = capture_high_byte_q;
        capture_low_byte_d  = capture_low_byte_q;
        flag_d              = flag_q;
        mask_d              = mask_q;
        ev_smp_d            = ev_smp_q;
        tr_smp_d            = tr_smp_q;
        ev_pend_d           = ev_pend_q;
        baud_d              = 1'b0;

        // pin sampling once per machine cycle
        // a level shorter than one machine cycle may fall between two
        // samples and be lost; the source must hold each level long enough.
        // the sample registers reset low, below the idle-high pin level, so
        // no falling edge can be invented by the first sample after reset
        if (at_sample) begin
            ev_smp_d = event_count_input;
            tr_smp_d = external_trigger_input;
            // high then low across two samples marks an edge
            if (ev_smp_q && !event_count_input) begin
                ev_pend_d = 1'b1;
            end
        end
        if (at_update) begin
            ev_pend_d = 1'b0;  // edge consumed or dropped when stopped
        end

        // counting
        if (inc) begin
            count_high_byte_d = next_count[15:8];
            count_low_byte_d  = next_count[7:0];
        end

        // overflow handling per mode
        // overflow is only ever raised together with inc, so a stopped
        // counter can never set a flag or reload; capture mode simply wraps
        // to zero, reload and baud modes load the capture bytes instead.
        // baud mode rolls over silently apart from its one-clock tick,
        // so software sees no flag and no interrupt from it
        if (overflow) begin
            case (mode)
                TCC_CAPTURE: begin
                    flag_d[TCC_OVF_BIT] = 1'b1;
                end
                TCC_RELOAD: begin
                    flag_d[TCC_OVF_BIT] = 1'b1;
                    count_high_byte_d   = capture_high_byte_q;
                    count_low_byte_d    = capture_low_byte_q;
                end
                TCC_BAUD: begin
                    baud_d            = 1'b1;
                    count_high_byte_d = capture_high_byte_q;
                    count_low_byte_d  = capture_low_byte_q;
                end
                default: begin
                end
            endcase
        end

        // external trigger in capture mode
        // the copy takes the count as it stood before this clock, so a
        // capture that lands on an increment records the older value;
        // in reload and baud modes the trigger edge is deliberately ignored
        // and the trigger sample is still updated so no stale edge remains
        if (trig_fall && external_trigger_enable && (mode == TCC_CAPTURE)) begin
            capture_high_byte_d = count_high_byte_q;
            capture_low_byte_d  = count_low_byte_q;
            flag_d[TCC_EXF_BIT] = 1'b1;
        end

        // software register writes
        // placed after the hardware updates so a write of the count or
        // capture bytes wins over an increment or capture in the same
        // clock; the status register is the exception, where a hardware
        // set must not be lost to a clear that arrives in the same cycle.
        // writes to holes in the map change nothing and answer pslverr
        if (wr_en) begin
            case (paddr)
                TCC_CTRL_OFS: ctrl_d = pwdata[5:0];
                TCC_COUNT_OFS: begin
                    count_high_byte_d = pwdata[15:8];
                    count_low_byte_d  = pwdata[7:0];
                end
                TCC_CAPT_OFS: begin
                    capture_high_byte_d = pwdata[15:8];
                    capture_low_byte_d  = pwdata[7:0];
                end
                TCC_STAT_OFS: begin
                    // write one clears, but a flag set this clock survives
                    flag_d = (flag_q & ~pwdata[1:0]) | (flag_d & ~flag_q);
                end
                TCC_MASK_OFS: mask_d = pwdata[1:0];
                default: begin
                end
            endcase
        end

        // interrupt: or of unmasked flags, registered
        irq_d = |(flag_d & mask_d);

        // apb answer, zero-wait
        // the answer is prepared in the setup cycle and registered, so it
        // stands for exactly the access cycle; a master that holds its
        // request longer than that would see pready low again and wait on.
        // unmapped addresses answer with an error and read back zero,
        // which keeps a failed read from showing stale data
        pready_d  = psel && !penable;
        pslverr_d = psel && !penable && !addr_ok;
        prdata_d  = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                TCC_CTRL_OFS:  prdata_d = {26'h0, ctrl_q};
                TCC_COUNT_OFS: prdata_d = {16'h0, count_high_byte_q, count_low_byte_q};
                TCC_CAPT_OFS:  prdata_d = {16'h0, capture_high_byte_q, capture_low_byte_q};
                TCC_STAT_OFS:  prdata_d = {30'h0, flag_q};
                TCC_MASK_OFS:  prdata_d = {30'h0, mask_q};
                default:       prdata_d = 32'h0000_0000;
            endcase
        end
    end

    // all state registers; async reset to constants
    // this process only registers the next values computed above; the
    // reset branch assigns constants alone, so the asynchronous path never
    // depends on other state. the counter comes out of reset stopped,
    // with flags and mask clear, so irq stays low until software acts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q             <= 4'h0;
            ctrl_q              <= TCC_CTRL_RST;
            count_high_byte_q   <= TCC_COUNT_RST[15:8];
            count_low_byte_q    <= TCC_COUNT_RST[7:0];
            capture_high_byte_q <= TCC_COUNT_RST[15:8];
            capture_low_byte_q  <= TCC_COUNT_RST[7:0];
            flag_q              <= TCC_FLAG_RST;
            mask_q              <= TCC_FLAG_RST;
            ev_smp_q            <= 1'b0;
            tr_smp_q            <= 1'b0;
            ev_pend_q           <= 1'b0;
            prdata_q            <= 32'h0000_0000;
            pready_q            <= 1'b0;
            pslverr_q           <= 1'b0;
            irq_q               <= 1'b0;
            baud_q              <= 1'b0;
        end else begin
            phase_q             <= phase_d;
            ctrl_q              <= ctrl_d;
            count_high_byte_q   <= count_high_byte_d;
            count_low_byte_q    <= count_low_byte_d;
            capture_high_byte_q <= capture_high_byte_d;
            capture_low_byte_q  <= capture_low_byte_d;
            flag_q              <= flag_d;
            mask_q              <= mask_d;
            ev_smp_q            <= ev_smp_d;
            tr_smp_q            <= tr_smp_d;
            ev_pend_q           <= ev_pend_d;
            prdata_q            <= prdata_d;
            pready_q            <= pready_d;
            pslverr_q           <= pslverr_d;
            irq_q               <= irq_d;
            baud_q              <= baud_d;
        end
    end

    // outputs straight from flip-flops
    // no logic sits between these registers and the pins, so the bus and
    // interrupt outputs carry no glitches; irq and baud_tick rise on the
    // same edge that sets the flag or reloads the count, so a user timing
    // an interrupt response against the count need allow no extra clock
    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign irq       = irq_q;
    assign baud_tick = baud_q;

endmodule

`default_nettype wire

// file: testbench/tcc_pins_model.sv
// tcc_pins_model: far-side sources for the count and trigger pins
// assumes pclk is the oscillator clock; levels change just after rising edges
`timescale 1ns/1ns
`default_nettype none

module tcc_pins_model (
    // clock
    input  wire logic pclk,
    // pins into the block
    output var logic  event_count_input,
    output var logic  external_trigger_input
);
    // both idle high so the first low is a real falling edge
    initial begin
        event_count_input      = 1'b1;
        external_trigger_input = 1'b1;
    end

    // n falling edges; every level lasts a full machine cycle or more
    task automatic count_pulses(input int n);
        repeat (n) begin
            repeat (12) @(posedge pclk);
            event_count_input <= 1'b0;
            repeat (12) @(posedge pclk);
            event_count_input <= 1'b1;
        end
    endtask

    // one falling edge on the trigger, low long enough to be sampled
    task automatic trigger_fall();
        repeat (12) @(posedge pclk);
        external_trigger_input <= 1'b0;
        repeat (24) @(posedge pclk);
        external_trigger_input <= 1'b1;
    endtask
endmodule

`default_nettype wire

// file: testbench/tcc_timer_monitor.sv
// tcc_timer_monitor: port-level checks on the timer block
// assumes one clock domain, pclk, with async active-low presetn
`timescale 1ns/1ns
`default_nettype none

module tcc_timer_monitor
    import tcc_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // pins and outputs
    input  wire logic        event_count_input,
    input  wire logic        external_trigger_input,
    input  wire logic        irq,
    input  wire logic        baud_tick
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic mapped;  // address hits one of the five registers
    assign mapped = paddr inside {TCC_CTRL_OFS, TCC_COUNT_OFS, TCC_CAPT_OFS,
                                  TCC_STAT_OFS, TCC_MASK_OFS};

    // answer comes in the access cycle and lasts one cycle
    a_pready_answer: assert property (psel && !penable |=> pready && penable)
        else $error("pready missing after setup");
    a_pready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    // error response only with an answer, and only for holes in the map
    a_slverr_with: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_slverr_map: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match address decode");
    a_unmapped_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    // flags are sticky: irq drops only after a software write
    a_irq_sticky: assert property ($fell(irq) |-> $past(psel && penable && pwrite)
                                   || $past(psel && penable && pwrite, 2))
        else $error("irq fell without a write");
    // rollovers at least nine clocks apart
    a_baud_spacing: assert property (baud_tick |=> !baud_tick [*8])
        else $error("baud ticks too close");
    a_reset_quiet: assert property ($rose(presetn) |-> !irq && !pready && !baud_tick)
        else $error("outputs active out of reset");

    c_irq:   cover property ($rose(irq));
    c_baud:  cover property (baud_tick);
    c_error: cover property (pready && pslverr);
endmodule

bind tcc_timer tcc_timer_monitor i_tcc_timer_monitor (.*);

`default_nettype wire

// file: testbench/tcc_timer_test.sv
// tcc_timer_test: register-level tests of the timer block over apb
// assumes the pin model holds each level for one machine cycle or more
`timescale 1ns/1ns
`default_nettype none

module tcc_timer_test;
    import tcc_pkg::*;

    logic        pclk, presetn, psel, penable, pwrite;  // bus controls
    logic [7:0]  paddr;                                 // byte address
    logic [31:0] pwdata, prdata, q, q2;                 // data and readbacks
    logic        pready, pslverr, e, irq, baud_tick;    // answers
    wire         ev_pin, trig_pin;                      // from the pin model
    logic        tick_seen = 1'b0;                      // baud rollover noted
    int          error_cnt = 0, comparisons = 0, cyc = 0;
    localparam logic [31:0] CT = 32'h1 << TCC_CT_SEL_BIT, RUN = 32'h1 << TCC_RUN_BIT;
    localparam logic [31:0] CPRL = 32'h1 << TCC_CPRL_BIT, EXEN = 32'h1 << TCC_EXEN_BIT;
    localparam logic [31:0] TX = 32'h1 << TCC_TXBAUD_BIT;
    logic [7:0] regs [5] = '{TCC_CTRL_OFS, TCC_COUNT_OFS, TCC_CAPT_OFS,
                             TCC_STAT_OFS, TCC_MASK_OFS};

    tcc_timer i_tcc_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_count_input(ev_pin), .external_trigger_input(trig_pin),
        .irq(irq), .baud_tick(baud_tick));
    tcc_pins_model i_tcc_pins_model (.pclk(pclk), .event_count_input(ev_pin),
        .external_trigger_input(trig_pin));

    // 100 ns clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // hang guard, far above the several hundred cycles the tests use
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (baud_tick === 1'b1) tick_seen <= 1'b1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            close_out();
        end
    end

    task automatic close_out();
        if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rq, output logic re);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q2, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, q2, e);
        cmp(q2, exp);
    endtask

    // main sequence
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        foreach (regs[i]) rd(regs[i], 32'h0);
        apb(1'b0, 8'h20, 32'h0, q, e);
        cmp(q, 32'h0);
        cmp({31'h0, e}, 32'h1);
        // timer in capture mode: one step per 12 clocks, then wrap
        wr(TCC_COUNT_OFS, 32'h0000fff0);
        wr(TCC_CTRL_OFS, RUN | CPRL);
        apb(1'b0, TCC_COUNT_OFS, 32'h0, q, e);
        repeat (117) @(posedge pclk);
        apb(1'b0, TCC_COUNT_OFS, 32'h0, q2, e);
        cmp(q2 - q, 32'd10);
        repeat (120) @(posedge pclk);
        rd(TCC_STAT_OFS, 32'h1);
        wr(TCC_MASK_OFS, 32'h1);
        repeat (3) @(posedge pclk);
        cmp({31'h0, irq}, 32'h1);
        wr(TCC_STAT_OFS, 32'h1);
        repeat (3) @(posedge pclk);
        cmp({31'h0, irq}, 32'h0);
        // stopped counter holds its value
        wr(TCC_CTRL_OFS, CPRL | TX | EXEN);
        apb(1'b0, TCC_COUNT_OFS, 32'h0, q, e);
        repeat (60) @(posedge pclk);
        rd(TCC_COUNT_OFS, q);
        // event counting of falling edges, then a capture
        wr(TCC_COUNT_OFS, 32'h0000_00ff);
        wr(TCC_CTRL_OFS, RUN | CPRL | CT);
        i_tcc_pins_model.count_pulses(5);
        repeat (30) @(posedge pclk);
        rd(TCC_COUNT_OFS, 32'h0000_0104);
        wr(TCC_CTRL_OFS, RUN | CPRL | CT | EXEN);
        i_tcc_pins_model.trigger_fall();
        repeat (30) @(posedge pclk);
        rd(TCC_CAPT_OFS, 32'h0000_0104);
        rd(TCC_STAT_OFS, 32'h2);
        cmp({31'h0, irq}, 32'h0);
        wr(TCC_MASK_OFS, 32'h2);
        repeat (3) @(posedge pclk);
        cmp({31'h0, irq}, 32'h1);
        wr(TCC_STAT_OFS, 32'h2);
        // auto-reload from the capture bytes on overflow
        wr(TCC_CTRL_OFS, 32'h0);
        wr(TCC_CAPT_OFS, 32'h0000_1234);
        wr(TCC_COUNT_OFS, 32'h0000_fffe);
        wr(TCC_CTRL_OFS, RUN);
        repeat (48) @(posedge pclk);
        wr(TCC_CTRL_OFS, 32'h0);
        apb(1'b0, TCC_COUNT_OFS, 32'h0, q, e);
        cmp({24'h0, q[15:8]}, 32'h12);
        rd(TCC_STAT_OFS, 32'h1);
        // baud mode: rollover with no flag
        wr(TCC_STAT_OFS, 32'h3);
        wr(TCC_COUNT_OFS, 32'h0000_fffe);
        wr(TCC_CTRL_OFS, RUN | TX | CPRL);
        repeat (48) @(posedge pclk);
        wr(TCC_CTRL_OFS, 32'h0);
        rd(TCC_STAT_OFS, 32'h0);
        cmp({31'h0, tick_seen}, 32'h1);
        close_out();
    end
endmodule

`default_nettype wire
